// ### logic/gpx_cfg.svh
/*
  Constants of the 16-line two-wire I/O expander: slave address, register
  pointer codes, reset values, noise filter timing and bus register offsets.
  Assumes a 20 MHz system clock and inclusion by every design file except the package.
*/
//
// Behaviour
// - Sixteen I/O lines form two 8-bit ports, each with direction, input, output and inversion.
// - After reset every line is an input and no pin is driven until direction is changed.
// - Each pin is driven or released according to its own stored direction bit.
// - The input register holds sampled input levels and the output register the drive levels.
// - An input bit is reported inverted when its inversion bit is set, otherwise unchanged.
// - A low reset pin restores all registers and restarts the serial state machine.
// - The interrupt pin is pulled low while any input differs from its captured value.
// - One slave address bit is taken from the address-select pin.
// - The serial slave works with serial clock rates up to 400 kHz.
// - Output pins hold latched values and change only when the output register is written.
// - Short spikes on the serial clock and data are filtered before the state machine.
// - The last bit of the address byte is 1 for a read and 0 for a write.
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

`define GPX_ADDR_HI 6'h10
`define GPX_GRP_IN 2'h0
`define GPX_GRP_OUT 2'h1
`define GPX_GRP_INV 2'h2
`define GPX_GRP_CFG 2'h3
`define GPX_OUT_RST 16'hffff
`define GPX_INV_RST 16'h0000
`define GPX_CFG_RST 16'hffff

`define GPX_CLK_NS 50
`define GPX_SPIKE_NS 50
`define GPX_FILT_CYC ((`GPX_SPIKE_NS + `GPX_CLK_NS - 1) / `GPX_CLK_NS + 1)
`define GPX_SCL_MAX_KHZ 400
`define GPX_SCL_HALF_CYC (1000000 / (2 * `GPX_SCL_MAX_KHZ) / `GPX_CLK_NS)

`define GPX_AX_STATUS 8'h00
`define GPX_AX_MASK 8'h04
`define GPX_AX_VIEW_A 8'h08
`define GPX_AX_VIEW_B 8'h0c
`define GPX_EV_PIN 0
`define GPX_EV_WR 1
`define GPX_EV_RD 2
`define GPX_NEV 3

`endif

// ### logic/gpx_pkg.sv
/*
  Types of the I/O expander: serial state machine states and AXI responses.
  Assumes nothing of its surroundings.
*/
package gpx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h2,
    ST_WR_BYTE = 3'h3,
    ST_RD_BYTE = 3'h4,
    ST_RD_ACK = 3'h5
  } i2c_state_e;

  typedef logic [1:0] resp_t;
  localparam resp_t RESP_OKAY = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;

endpackage

// ### logic/spike_filter.sv
/*
  Two-flop synchroniser followed by a stability filter for one serial line.
  Assumes an asynchronous input and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "gpx_cfg.svh"

module spike_filter
#(
  parameter int FILT_CYC = `GPX_FILT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);

  logic s1_ff, s2_ff, q_ff, nxt_q;
  logic [3:0] cnt_ff, nxt_cnt;

  // Delay is FILT_CYC+2 cycles, far below a fast-mode half period
  always_comb
  begin
    nxt_q = q_ff;
    nxt_cnt = 4'h0;
    if (s2_ff != q_ff)
    begin
      nxt_cnt = cnt_ff + 4'h1;
      if (cnt_ff == 4'(FILT_CYC - 1))
      begin
        nxt_q = s2_ff;
        nxt_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      q_ff <= 1'b1;
      cnt_ff <= 4'h0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      q_ff <= nxt_q;
      cnt_ff <= nxt_cnt;
    end
  end

  assign dout = q_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  spike_reject_a: assert property ($changed(q_ff) |-> $past(s2_ff, 1) == q_ff
    && $past(s2_ff, 2) == q_ff)
    else $error("filtered line changed without a stable input");

endmodule

// ### logic/axil_event_regs.sv
/*
  AXI4-Lite slave holding the event status, interrupt mask and two views.
  Assumes a master keeping one write and one read outstanding at most.
*/
`timescale 1ns/1ns
`include "gpx_cfg.svh"

module axil_event_regs
  import gpx_pkg::*;
#(
  parameter int NEV = `GPX_NEV
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NEV-1:0] event_pulse,
  input wire logic [31:0] view_a,
  input wire logic [31:0] view_b,
  output logic irq
);

  logic aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok, do_wr;
  logic [7:0] wa_ff, nxt_wa;
  logic [31:0] wd_ff, nxt_wd, rdata_ff, nxt_rdata;
  logic [3:0] ws_ff, nxt_ws;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid, irq_ff, nxt_irq;
  logic awready_ff, wready_ff, arready_ff;
  resp_t bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [NEV-1:0] status_ff, nxt_status, mask_ff, nxt_mask, clr;
  logic [7:0] wa_w, ra_w;

  always_comb
  begin
    nxt_aw_ok = aw_ok_ff;
    nxt_w_ok = w_ok_ff;
    nxt_wa = wa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_mask = mask_ff;
    clr = '0;
    if (awvalid && !aw_ok_ff)
    begin
      nxt_aw_ok = 1'b1;
      nxt_wa = awaddr;
    end
    if (wvalid && !w_ok_ff)
    begin
      nxt_w_ok = 1'b1;
      nxt_wd = wdata;
      nxt_ws = wstrb;
    end
    wa_w = {wa_ff[7:2], 2'h0};
    do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
    if (do_wr)
    begin
      nxt_aw_ok = 1'b0;
      nxt_w_ok = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (wa_w == `GPX_AX_STATUS && ws_ff[0])
        clr = wd_ff[NEV-1:0];
      else if (wa_w == `GPX_AX_MASK && ws_ff[0])
        nxt_mask = wd_ff[NEV-1:0];
      else if (wa_w != `GPX_AX_VIEW_A && wa_w != `GPX_AX_VIEW_B)
        nxt_bresp = RESP_SLVERR;
    end
    else if (bvalid_ff && bready)
      nxt_bvalid = 1'b0;
    ra_w = {araddr[7:2], 2'h0};
    if (arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      if (ra_w == `GPX_AX_STATUS)
        nxt_rdata[NEV-1:0] = status_ff;
      else if (ra_w == `GPX_AX_MASK)
        nxt_rdata[NEV-1:0] = mask_ff;
      else if (ra_w == `GPX_AX_VIEW_A)
        nxt_rdata = view_a;
      else if (ra_w == `GPX_AX_VIEW_B)
        nxt_rdata = view_b;
      else
        nxt_rresp = RESP_SLVERR;
    end
    else if (rvalid_ff && rready)
      nxt_rvalid = 1'b0;
    // A new event wins over a clear in the same cycle
    nxt_status = (status_ff & ~clr) | event_pulse;
    nxt_irq = |(status_ff & mask_ff);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      wa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      status_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
    end
    else
    begin
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
      wa_ff <= nxt_wa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      // Ready lines kept as their own flops so the ports come from registers
      awready_ff <= !nxt_aw_ok;
      wready_ff <= !nxt_w_ok;
      arready_ff <= !nxt_rvalid;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign irq = irq_ff;

endmodule

// ### logic/gpx_top.sv
/*
  Sixteen-line I/O expander: two-wire serial slave, port registers, change
  interrupt, and an AXI4-Lite window for event status. Assumes pins arrive
  asynchronously and that the pad logic resolves the open-drain enables.
*/
`timescale 1ns/1ns
`include "gpx_cfg.svh"

module gpx_top
  import gpx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset_n,
  input wire logic addr_sel,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  input wire logic [15:0] gpio_i,
  output logic [15:0] gpio_o,
  output logic [15:0] gpio_oe,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filtered serial lines

  logic [15:0] pin_s1_ff, pin_s2_ff;
  logic addr_s1_ff, addr_s2_ff, rst_s1_ff, rst_s2_ff;
  logic scl_f, sda_f, scl_d_ff, sda_d_ff, rst_all;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= 1'b1;
    end
    else
    begin
      rst_s1_ff <= ext_reset_n;
      rst_s2_ff <= rst_s1_ff;
    end
    pin_s1_ff <= gpio_i;
    pin_s2_ff <= pin_s1_ff;
    addr_s1_ff <= addr_sel;
    addr_s2_ff <= addr_s1_ff;
  end

  // Reset pin acts like the power-on reset on every register
  assign rst_all = !aresetn || !rst_s2_ff;

  spike_filter scl_filt (
    .aclk(aclk),
    .aresetn(!rst_all),
    .din(scl_i),
    .dout(scl_f)
  );

  spike_filter sda_filt (
    .aclk(aclk),
    .aresetn(!rst_all),
    .din(sda_i),
    .dout(sda_f)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave and port registers

  // Bits 7:0 are bank0_line0 upward, bits 15:8 bank1_line0 upward
  i2c_state_e st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt, ptr_ff, nxt_ptr;
  logic [7:0] shift_ff, nxt_shift, sh_in, rd_byte;
  logic rw_ff, nxt_rw, first_ff, nxt_first, ph_ff, nxt_ph, sda_oe_ff, nxt_sda_oe;
  logic [15:0] out_ff, nxt_out, inv_ff, nxt_inv, cfg_ff, nxt_cfg, in_ff, nxt_in;
  logic [15:0] oe_ff;
  logic start, stop, scl_rise, scl_fall, addr_hit, load, ev_wr, ev_rd;
  logic chg, int_oe_ff, chg_d_ff;

  function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction

  assign start = scl_f && scl_d_ff && sda_d_ff && !sda_f;
  assign stop = scl_f && scl_d_ff && !sda_d_ff && sda_f;
  assign scl_rise = scl_f && !scl_d_ff;
  assign scl_fall = !scl_f && scl_d_ff;
  assign addr_hit = shift_ff[6:0] == {`GPX_ADDR_HI, addr_s2_ff};
  assign sh_in = {shift_ff[6:0], sda_f};

  always_comb
  begin
    unique case (ptr_ff[2:1])
      `GPX_GRP_IN: rd_byte = pick(pin_s2_ff ^ inv_ff, ptr_ff[0]);
      `GPX_GRP_OUT: rd_byte = pick(out_ff, ptr_ff[0]);
      `GPX_GRP_INV: rd_byte = pick(inv_ff, ptr_ff[0]);
      `GPX_GRP_CFG: rd_byte = pick(cfg_ff, ptr_ff[0]);
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ptr = ptr_ff;
    nxt_shift = shift_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_ph = ph_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_out = out_ff;
    nxt_inv = inv_ff;
    nxt_cfg = cfg_ff;
    nxt_in = in_ff;
    load = 1'b0;
    ev_wr = 1'b0;
    ev_rd = 1'b0;
    if (start)
    begin
      nxt_st = ST_ADDR;
      nxt_cnt = 3'h0;
      nxt_ph = 1'b0;
      nxt_sda_oe = 1'b0;
    end
    else if (stop)
    begin
      nxt_st = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else
    begin
      unique case (st_ff)
        ST_IDLE:
          nxt_sda_oe = 1'b0;
        ST_ADDR:
          if (scl_rise)
          begin
            nxt_shift = sh_in;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7)
            begin
              nxt_rw = sda_f;
              nxt_first = 1'b1;
              nxt_ph = 1'b0;
              nxt_st = addr_hit ? ST_ACK : ST_IDLE;
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            nxt_ph = !ph_ff;
            nxt_sda_oe = !ph_ff;
            nxt_cnt = 3'h0;
            if (ph_ff && rw_ff)
            begin
              load = 1'b1;
              nxt_st = ST_RD_BYTE;
              nxt_shift = rd_byte;
              nxt_sda_oe = !rd_byte[7];
              nxt_ptr = ptr_ff + 3'h1;
            end
            else if (ph_ff)
              nxt_st = ST_WR_BYTE;
          end
        ST_WR_BYTE:
          if (scl_rise)
          begin
            nxt_shift = sh_in;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7)
            begin
              nxt_st = ST_ACK;
              nxt_first = 1'b0;
              if (first_ff)
                nxt_ptr = sh_in[2:0];
              else
              begin
                nxt_ptr = ptr_ff + 3'h1;
                ev_wr = 1'b1;
                // Input group is read-only, writes there are dropped
                unique case ({ptr_ff[2:1], ptr_ff[0]})
                  {`GPX_GRP_OUT, 1'b0}: nxt_out[7:0] = sh_in;
                  {`GPX_GRP_OUT, 1'b1}: nxt_out[15:8] = sh_in;
                  {`GPX_GRP_INV, 1'b0}: nxt_inv[7:0] = sh_in;
                  {`GPX_GRP_INV, 1'b1}: nxt_inv[15:8] = sh_in;
                  {`GPX_GRP_CFG, 1'b0}: nxt_cfg[7:0] = sh_in;
                  {`GPX_GRP_CFG, 1'b1}: nxt_cfg[15:8] = sh_in;
                  default: ev_wr = 1'b0;
                endcase
              end
            end
          end
        ST_RD_BYTE:
        begin
          if (scl_rise)
          begin
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7)
              nxt_st = ST_RD_ACK;
          end
          if (scl_fall)
          begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_sda_oe = !shift_ff[6];
          end
        end
        ST_RD_ACK:
        begin
          if (scl_fall)
            nxt_sda_oe = 1'b0;
          if (scl_rise && sda_f)
          begin
            nxt_st = ST_IDLE;
            ev_rd = 1'b1;
          end
          else if (scl_rise)
          begin
            nxt_st = ST_ACK;
            nxt_ph = 1'b1;
          end
        end
      endcase
    end
    // Reading the input group recaptures the pins and clears the change
    if (load && ptr_ff[2:1] == `GPX_GRP_IN && ptr_ff[0])
      nxt_in[15:8] = pin_s2_ff[15:8];
    else if (load && ptr_ff[2:1] == `GPX_GRP_IN)
      nxt_in[7:0] = pin_s2_ff[7:0];
  end

  assign chg = |(pin_s2_ff ^ in_ff);

  always_ff @(posedge aclk)
  begin
    scl_d_ff <= scl_f;
    sda_d_ff <= sda_f;
    if (rst_all)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      ptr_ff <= 3'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      ph_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      out_ff <= `GPX_OUT_RST;
      inv_ff <= `GPX_INV_RST;
      cfg_ff <= `GPX_CFG_RST;
      oe_ff <= 16'h0000;
      in_ff <= pin_s2_ff;
      int_oe_ff <= 1'b0;
      chg_d_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ptr_ff <= nxt_ptr;
      shift_ff <= nxt_shift;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      ph_ff <= nxt_ph;
      sda_oe_ff <= nxt_sda_oe;
      out_ff <= nxt_out;
      inv_ff <= nxt_inv;
      cfg_ff <= nxt_cfg;
      oe_ff <= ~nxt_cfg;
      in_ff <= nxt_in;
      int_oe_ff <= chg;
      chg_d_ff <= chg;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign int_o = 1'b0;
  assign int_oe = int_oe_ff;
  assign gpio_o = out_ff;
  assign gpio_oe = oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Event status over AXI4-Lite

  axil_event_regs regs (
    .aclk(aclk),
    .aresetn(!rst_all),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .event_pulse({ev_rd, ev_wr, chg && !chg_d_ff}),
    .view_a({cfg_ff, out_ff}),
    .view_b({pin_s2_ff, in_ff}),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (rst_all);

  dir_after_reset_a: assert property ($past(rst_all) |-> gpio_oe == 16'h0000)
    else $error("pin driven right after reset");
  dir_follows_cfg_a: assert property (gpio_oe == ~cfg_ff)
    else $error("pin enable disagrees with direction");
  out_latched_a: assert property ($changed(gpio_o) |-> $past(ev_wr))
    else $error("output changed without a register write");
  int_tracks_a: assert property (int_oe == $past(|(pin_s2_ff ^ in_ff)))
    else $error("interrupt does not follow input change");
  addr_match_a: assert property ($past(st_ff) == ST_ADDR && st_ff == ST_ACK |->
    $past(addr_hit) && !sda_oe)
    else $error("acknowledged a foreign address");
  read_dir_a: assert property (st_ff == ST_ACK ##1 st_ff == ST_RD_BYTE |-> rw_ff)
    else $error("read started on a write address");
  inv_report_a: assert property (load && ptr_ff[2:1] == `GPX_GRP_IN && !ptr_ff[0] |=>
    shift_ff == $past(pin_s2_ff[7:0] ^ inv_ff[7:0]))
    else $error("input byte not reported through inversion");
  recapture_a: assert property (load && ptr_ff == 3'h0 |=>
    in_ff[7:0] == $past(pin_s2_ff[7:0]) ##1 (in_ff[7:0] == $past(in_ff[7:0]) || $past(load)))
    else $error("input read did not recapture pins");
  ack_drive_a: assert property (st_ff == ST_ACK && !ph_ff && scl_fall && !rw_ff |=>
    sda_oe && ph_ff)
    else $error("acknowledge not driven");

  addr_ack_c: cover property (st_ff == ST_ADDR ##1 st_ff == ST_ACK);
  reg_write_c: cover property (ev_wr);
  read_done_c: cover property (ev_rd);
  int_pulled_c: cover property ($rose(int_oe));

endmodule

// ### tb/i2c_master_model.sv
/*
  Behavioural two-wire bus master that stands in for the system controller.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ns
module i2c_master_model
(
  input wire logic aclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Five cycles low, three high: 400 ns bit time
  // Long low half covers the slave's filtered release of the data line
  task automatic xfer(input logic b, output logic s);
    wt(2);
    sda_low <= ~b;
    wt(3);
    scl <= 1'b1;
    wt(3);
    s = sda;
    scl <= 1'b0;
  endtask

  task automatic start;
    wt(2);
    sda_low <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b1;
    wt(4);
    scl <= 1'b0;
  endtask

  task automatic stop;
    wt(2);
    sda_low <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_low <= 1'b0;
    wt(4);
  endtask

  task automatic put(input logic [7:0] v, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer(v[i], s);
    xfer(1'b1, s);
    ok = ok & ~s;
  endtask

  task automatic get(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      xfer(1'b1, s);
      v[i] = s;
    end
    xfer(last, s);
  endtask

  // Pointer and data bytes come from the bench
  task automatic wr(input logic [6:0] a, input logic [2:0] p,
                    input logic [15:0] d, output logic ok);
    ok = 1'b1;
    start();
    put({a, 1'b0}, ok);
    put({5'h00, p}, ok);
    put(d[7:0], ok);
    put(d[15:8], ok);
    stop();
  endtask

  task automatic rd(input logic [6:0] a, input logic [2:0] p,
                    output logic [15:0] d, output logic ok);
    ok = 1'b1;
    start();
    put({a, 1'b0}, ok);
    put({5'h00, p}, ok);
    start();
    put({a, 1'b1}, ok);
    get(1'b0, d[7:0]);
    get(1'b1, d[15:8]);
    stop();
  endtask
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench for the two-wire I/O expander with its event window.
  Assumes the design files and the bus master model are compiled first.
*/
`timescale 1ns/1ns
module testbench
  import gpx_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ext_reset_n = 1'b1;
  logic addr_sel = 1'b0;
  logic [6:0] dev = 7'h20;
  logic scl, m_low, sda_o, sda_oe, int_o, int_oe, irq;
  logic [15:0] gpio_i = 16'h0000;
  logic [15:0] ext = 16'h0000;
  logic [15:0] gpio_o, gpio_oe;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int failures = 0;
  int total_checks = 0;
  wire sda = ~(m_low | (sda_oe & ~sda_o));
  wire int_n = ~(int_oe & ~int_o);

  typedef struct packed {
    logic [15:0] cfg, out, inv, pins, rd;
  } row_s;
  row_s rows [3] = '{
    '{16'hffff, 16'h0000, 16'h0000, 16'ha5c3, 16'ha5c3},
    '{16'h00ff, 16'h1234, 16'hff00, 16'h00f0, 16'hedf0},
    '{16'hff00, 16'h8001, 16'h0f0f, 16'h5a5a, 16'h550e}
  };

  always #25 aclk = ~aclk;

  // Driven pins read back their own level
  always @(posedge aclk)
    gpio_i <= (gpio_oe & gpio_o) | (~gpio_oe & ext);

  gpx_top i_gpx_top (.aclk(aclk), .aresetn(aresetn), .ext_reset_n(ext_reset_n),
    .addr_sel(addr_sel), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .int_o(int_o), .int_oe(int_oe), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  i2c_master_model i_i2c_master_model (.aclk(aclk), .sda(sda), .scl(scl),
    .sda_low(m_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while ((awvalid & ~awready) | (wvalid & ~wready));
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic iw(input logic [2:0] p, input logic [15:0] d);
    logic ok;
    i_i2c_master_model.wr(dev, p, d, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  task automatic ir(input logic [2:0] p, output logic [15:0] d);
    logic ok;
    i_i2c_master_model.rd(dev, p, d, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0] r;
    logic ok;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({gpio_oe, gpio_o}, 32'h0000_ffff);
    chk({31'h0, int_n}, 32'h1);
    ir(3'h6, v);
    chk({16'h0, v}, 32'h0000_ffff);
    done("reset");
    foreach (rows[i])
    begin
      iw(3'h6, rows[i].cfg);
      iw(3'h2, rows[i].out);
      iw(3'h4, rows[i].inv);
      ext <= rows[i].pins;
      repeat (4) @(posedge aclk);
      chk({16'h0, gpio_oe}, {16'h0, ~rows[i].cfg});
      chk({16'h0, gpio_o}, {16'h0, rows[i].out});
      ir(3'h0, v);
      chk({16'h0, v}, {16'h0, rows[i].rd});
      axr(8'h08, d, r);
      chk(d, {rows[i].cfg, rows[i].out});
    end
    done("table");
    // Other address must be ignored, output latch untouched
    i_i2c_master_model.wr(7'h21, 3'h2, 16'h0000, ok);
    chk({31'h0, ok}, 32'h0);
    addr_sel <= 1'b1;
    dev = 7'h21;
    repeat (4) @(posedge aclk);
    ir(3'h2, v);
    chk({16'h0, v}, {16'h0, rows[2].out});
    done("address");
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_reset_n <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({gpio_oe, gpio_o}, 32'h0000_ffff);
    axr(8'h08, d, r);
    chk(d, 32'hffff_ffff);
    done("reset pin");
    // Released outputs moved the pins during reset, so recapture them
    ir(3'h0, v);
    repeat (4) @(posedge aclk);
    chk({31'h0, int_n}, 32'h1);
    axw(8'h00, 32'h0000_0007);
    ext <= ext ^ 16'h0100;
    repeat (8) @(posedge aclk);
    chk({31'h0, int_n}, 32'h0);
    ext <= ext ^ 16'h0100;
    repeat (8) @(posedge aclk);
    chk({31'h0, int_n}, 32'h1);
    ext <= ext ^ 16'h0001;
    axw(8'h04, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    axr(8'h00, d, r);
    chk(d, 32'h0000_0001);
    axw(8'h00, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // Input group is read-only: this write must not show in the read
    iw(3'h0, 16'h0000);
    ir(3'h0, v);
    repeat (4) @(posedge aclk);
    chk({31'h0, int_n}, 32'h1);
    chk({16'h0, v}, {16'h0, ext});
    axr(8'h10, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0000_0000);
    done("interrupt");
    final_report();
  end

  initial
  begin
    repeat (40000) @(posedge aclk);
    failures++;
    final_report();
  end
endmodule
